/* File: verilog/sfg_guard.sv */
// Overview of operation
// - A rising edge of the arm trigger starts the fault window.
// - The window lasts the configured length in ms, up to 1800 s, 1 s default.
// - During the window any stage start trips instantly, with no delay.
// - The stage start input is the OR of all connected start signals.
// - The inhibit input stops the window from starting and shows blocked while no window is open.
// - Only binary input states steer the logic; no analog values are used.
// - The window length follows the selected setting group, even mid-window.
// - With forcing enabled the status is forced to normal, blocked, active or trip.
// - A readable condition code shows normal, init, active, trip or blocked.
// - Each change of init, block, active and trip makes an ON or OFF event.
// - A mask picks whether ON, OFF or both events are forwarded.
// - Clearable counters count init, blocked, active and trip ON events.
// - Each activation ON event is logged in a 12-entry circular log.
// - A log entry holds timestamp, event, setting group, time left, elapsed.
`timescale 1ns/1ps
`default_nettype none

module sfg_guard
  import sfg_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
)(
  input  wire logic             I_CLK,
  input  wire logic             I_RST_N,
  input  wire logic [ADR_W-1:0] I_WB_ADR,
  input  wire logic [31:0]      I_WB_DAT,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic             I_WB_WE,
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  output var  logic [31:0]      O_WB_DAT,
  output var  logic             O_WB_ACK,
  input  wire logic             I_ARM_TRIGGER_IN,
  input  wire logic             I_INHIBIT_IN,
  input  wire logic [FCN_W-1:0] I_STAGE_START_IN,
  output var  logic             O_WINDOW_ACTIVE_OUT,
  output var  logic             O_INSTANT_TRIP_OUT,
  output var  logic             O_INIT,
  output var  logic             O_BLOCKED,
  output var  logic             O_IRQ
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [16:0]       div_r, div_nxt;
  logic [31:0]       ts_r, ts_nxt;
  logic              tick;
  logic              ack_r, ack_nxt;
  logic              req, wr, rd;
  logic [31:0]       wmask, rd_word, wdat_m;
  logic [31:0]       rd_data_r, rd_data_nxt;
  logic              log_sel_r, log_sel_nxt;
  logic [1:0]        word_sel_r, word_sel_nxt;
  logic              force_en_r, force_en_nxt;
  logic [1:0]        force_sel_r, force_sel_nxt;
  logic [SG_W-1:0]   sg_r, sg_nxt;
  logic [7:0]        evmask_r, evmask_nxt;
  logic [7:0]        irqmask_r, irqmask_nxt;
  logic [7:0]        status_r, status_nxt;
  logic [TIME_W-1:0] winlen_r [NUM_GROUPS];
  logic [TIME_W-1:0] winlen_nxt [NUM_GROUPS];
  logic              cnt_clr;
  sfg_state_t        st_r, st_nxt;
  logic [TIME_W-1:0] elapsed_r, elapsed_nxt;
  logic [TIME_W-1:0] cur_len, left;
  logic              arm_prev_r;
  logic              trip_hold_r, trip_hold_nxt;
  logic              fcn_any, arm_rise, win_active;
  logic              raw_trip, raw_block;
  logic              out_init, out_block, out_act, out_trip;
  logic [2:0]        cond;
  logic [NUM_EVENTS-1:0] ev_now, ev_prev_r, ev_on, ev_off;
  logic [31:0]       cnt_r [NUM_EVENTS];
  logic [LOG_AW-1:0] head_r, head_nxt;
  logic [LOG_AW-1:0] count_r, count_nxt;
  logic [LOG_DW-1:0] log_entry, log_q;

  // ****************************************************************
  // Millisecond tick and timestamp
  // ****************************************************************
  always_comb begin
    tick    = (div_r == 17'(P_TICK_CYCLES - 1));
    div_nxt = tick ? 17'h0_0000 : div_r + 17'h0_0001;
    ts_nxt  = tick ? ts_r + 32'h0000_0001 : ts_r;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      div_r <= 17'h0_0000;
      ts_r  <= 32'h0000_0000;
    end else begin
      div_r <= div_nxt;
      ts_r  <= ts_nxt;
    end
  end

  // ****************************************************************
  // Fault window
  // ****************************************************************
  always_comb begin
    fcn_any  = |I_STAGE_START_IN;
    arm_rise = I_ARM_TRIGGER_IN & ~arm_prev_r;
    cur_len  = winlen_r[sg_r];
    st_nxt      = st_r;
    elapsed_nxt = elapsed_r;
    case (st_r)
      ST_IDLE: begin
        if (arm_rise && !I_INHIBIT_IN && cur_len != '0) begin
          st_nxt      = ST_WINDOW;
          elapsed_nxt = '0;
        end
      end
      ST_WINDOW: begin
        if (arm_rise && !I_INHIBIT_IN) begin
          elapsed_nxt = '0;
        end else if (elapsed_r >= cur_len) begin
          st_nxt = ST_IDLE;
        end else if (tick) begin
          elapsed_nxt = elapsed_r + 21'h00_0001;
          if (elapsed_nxt >= cur_len) begin
            st_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    win_active = (st_r == ST_WINDOW);
    left = (win_active && cur_len > elapsed_r) ? cur_len - elapsed_r : '0;
    raw_trip      = fcn_any & (win_active | trip_hold_r);
    trip_hold_nxt = raw_trip;
    raw_block     = I_INHIBIT_IN & ~win_active;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st_r        <= ST_IDLE;
      elapsed_r   <= '0;
      arm_prev_r  <= 1'b0;
      trip_hold_r <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      elapsed_r   <= elapsed_nxt;
      arm_prev_r  <= I_ARM_TRIGGER_IN;
      trip_hold_r <= trip_hold_nxt;
    end
  end

  // ****************************************************************
  // Forcing, outputs and condition
  // ****************************************************************
  always_comb begin
    out_init  = I_ARM_TRIGGER_IN;
    out_block = raw_block;
    out_act   = win_active;
    out_trip  = raw_trip;
    if (force_en_r) begin
      out_init  = 1'b0;
      out_block = (force_sel_r == FORCE_BLOCKED);
      out_act   = (force_sel_r == FORCE_ACTIVE);
      out_trip  = (force_sel_r == FORCE_TRIP);
    end
    if (out_block) begin
      cond = COND_BLOCKED;
    end else if (out_trip) begin
      cond = COND_TRIP;
    end else if (out_act) begin
      cond = COND_ACTIVE;
    end else if (out_init) begin
      cond = COND_INIT;
    end else begin
      cond = COND_NORMAL;
    end
    O_INIT              = out_init;
    O_BLOCKED           = out_block;
    O_WINDOW_ACTIVE_OUT = out_act;
    O_INSTANT_TRIP_OUT  = out_trip;
  end

  // ****************************************************************
  // Events, counters and log
  // ****************************************************************
  always_comb begin
    ev_now = '0;
    ev_now[EV_INIT]   = out_init;
    ev_now[EV_BLOCK]  = out_block;
    ev_now[EV_ACTIVE] = out_act;
    ev_now[EV_TRIP]   = out_trip;
    ev_on  = ev_now & ~ev_prev_r;
    ev_off = ~ev_now & ev_prev_r;
    head_nxt  = head_r;
    count_nxt = count_r;
    if (ev_on[EV_ACTIVE]) begin
      head_nxt = (head_r == 4'(LOG_DEPTH - 1)) ? '0 : head_r + 4'h1;
      if (count_r != 4'(LOG_DEPTH)) begin
        count_nxt = count_r + 4'h1;
      end
    end
    log_entry = {11'h000, elapsed_r, 11'h000, left,
                 16'h0000, LOG_EVENT_ACTIVE_ON, 5'h00, sg_r, ts_r};
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ev_prev_r <= '0;
      head_r    <= '0;
      count_r   <= '0;
    end else begin
      ev_prev_r <= ev_now;
      head_r    <= head_nxt;
      count_r   <= count_nxt;
    end
  end

  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_cnt
    logic [31:0] cnt_nxt;
    always_comb begin
      cnt_nxt = (cnt_clr ? 32'h0000_0000 : cnt_r[i]) + 32'(ev_on[i]);
    end
    always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
        cnt_r[i] <= 32'h0000_0000;
      end else begin
        cnt_r[i] <= cnt_nxt;
      end
    end
  end

  sfg_log_mem u_log (
    .I_CLK     (I_CLK),
    .i_wr_en   (ev_on[EV_ACTIVE]),
    .i_wr_addr (head_r),
    .i_wr_data (log_entry),
    .i_rd_addr (I_WB_ADR[7:4]),
    .o_rd_data (log_q)
  );

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  always_comb begin
    req   = I_WB_CYC & I_WB_STB & ~ack_r;
    wr    = req & I_WB_WE;
    rd    = req & ~I_WB_WE;
    wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
             {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    rd_word = 32'h0000_0000;
    case (I_WB_ADR)
      ADR_CTRL: begin
        rd_word[CTRL_FORCE_EN_BIT]           = force_en_r;
        rd_word[CTRL_FORCE_LSB +: 2]         = force_sel_r;
        rd_word[CTRL_SG_LSB +: SG_W]         = sg_r;
      end
      ADR_EVMASK:    rd_word[7:0] = evmask_r;
      ADR_STATUS:    rd_word[7:0] = status_r;
      ADR_IRQMASK:   rd_word[7:0] = irqmask_r;
      ADR_COND:      rd_word[2:0] = cond;
      ADR_LEFT:      rd_word[TIME_W-1:0] = left;
      ADR_ELAPSED:   rd_word[TIME_W-1:0] = elapsed_r;
      ADR_TIMESTAMP: rd_word = ts_r;
      ADR_LOGSTAT: begin
        rd_word[LOG_AW-1:0]                  = head_r;
        rd_word[LOGSTAT_CNT_LSB +: LOG_AW]   = count_r;
      end
      default: begin
        if ((I_WB_ADR & ADR_WINLEN_MASK) == ADR_WINLEN_BASE) begin
          rd_word[TIME_W-1:0] = winlen_r[I_WB_ADR[4:2]];
        end else if ((I_WB_ADR & ADR_CNT_MASK) == ADR_CNT_BASE) begin
          rd_word = cnt_r[I_WB_ADR[3:2]];
        end
      end
    endcase
    wdat_m = (rd_word & ~wmask) | (I_WB_DAT & wmask);

    force_en_nxt  = force_en_r;
    force_sel_nxt = force_sel_r;
    sg_nxt        = sg_r;
    evmask_nxt    = evmask_r;
    irqmask_nxt   = irqmask_r;
    winlen_nxt    = winlen_r;
    cnt_clr       = 1'b0;
    if (wr) begin
      case (I_WB_ADR)
        ADR_CTRL: begin
          force_en_nxt  = wdat_m[CTRL_FORCE_EN_BIT];
          force_sel_nxt = wdat_m[CTRL_FORCE_LSB +: 2];
          sg_nxt        = wdat_m[CTRL_SG_LSB +: SG_W];
          cnt_clr       = wdat_m[CTRL_CNT_CLR_BIT];
        end
        ADR_EVMASK:  evmask_nxt  = wdat_m[7:0];
        ADR_IRQMASK: irqmask_nxt = wdat_m[7:0];
        default: begin
          if ((I_WB_ADR & ADR_WINLEN_MASK) == ADR_WINLEN_BASE) begin
            winlen_nxt[I_WB_ADR[4:2]] =
              (wdat_m[TIME_W-1:0] > WINDOW_MAX_MS) ? WINDOW_MAX_MS
                                                   : wdat_m[TIME_W-1:0];
          end
        end
      endcase
    end

    status_nxt = ((rd && I_WB_ADR == ADR_STATUS) ? 8'h00 : status_r)
               | {ev_off & evmask_r[7:4], ev_on & evmask_r[3:0]};

    ack_nxt      = req;
    rd_data_nxt  = rd ? rd_word : rd_data_r;
    log_sel_nxt  = rd && ((I_WB_ADR & ADR_LOG_MASK) == ADR_LOG_BASE)
                      && (I_WB_ADR[7:4] < 4'(LOG_DEPTH));
    word_sel_nxt = rd ? I_WB_ADR[3:2] : word_sel_r;

    O_WB_ACK = ack_r;
    O_WB_DAT = log_sel_r ? log_q[word_sel_r*32 +: 32] : rd_data_r;
    O_IRQ    = |(status_r & irqmask_r);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ack_r       <= 1'b0;
      rd_data_r   <= 32'h0000_0000;
      log_sel_r   <= 1'b0;
      word_sel_r  <= 2'h0;
      force_en_r  <= 1'b0;
      force_sel_r <= FORCE_NORMAL;
      sg_r        <= '0;
      evmask_r    <= EVMASK_RESET;
      irqmask_r   <= IRQMASK_RESET;
      status_r    <= 8'h00;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        winlen_r[g] <= WINDOW_DEFAULT_MS;
      end
    end else begin
      ack_r       <= ack_nxt;
      rd_data_r   <= rd_data_nxt;
      log_sel_r   <= log_sel_nxt;
      word_sel_r  <= word_sel_nxt;
      force_en_r  <= force_en_nxt;
      force_sel_r <= force_sel_nxt;
      sg_r        <= sg_nxt;
      evmask_r    <= evmask_nxt;
      irqmask_r   <= irqmask_nxt;
      status_r    <= status_nxt;
      winlen_r    <= winlen_nxt;
    end
  end

endmodule : sfg_guard

`default_nettype wire

/* File: verilog/sfg_pkg.sv */
package sfg_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_KHZ   = 125000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES    = CLK_FREQ_KHZ * TICK_PERIOD_MS;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_GROUPS = 8;
  localparam int SG_W       = 3;
  localparam int NUM_EVENTS = 4;
  localparam int FCN_W      = 8;
  localparam int LOG_DEPTH  = 12;
  localparam int LOG_AW     = 4;
  localparam int LOG_DW     = 128;
  localparam int TIME_W     = 21;
  localparam int ADR_W      = 9;

  localparam logic [TIME_W-1:0] WINDOW_MAX_MS     = 21'h1B_7740;
  localparam logic [TIME_W-1:0] WINDOW_DEFAULT_MS = 21'h00_03E8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [ADR_W-1:0] ADR_CTRL        = 9'h000;
  localparam logic [ADR_W-1:0] ADR_EVMASK      = 9'h004;
  localparam logic [ADR_W-1:0] ADR_STATUS      = 9'h008;
  localparam logic [ADR_W-1:0] ADR_IRQMASK     = 9'h00C;
  localparam logic [ADR_W-1:0] ADR_COND        = 9'h010;
  localparam logic [ADR_W-1:0] ADR_LEFT        = 9'h014;
  localparam logic [ADR_W-1:0] ADR_ELAPSED     = 9'h018;
  localparam logic [ADR_W-1:0] ADR_TIMESTAMP   = 9'h01C;
  localparam logic [ADR_W-1:0] ADR_LOGSTAT     = 9'h020;
  localparam logic [ADR_W-1:0] ADR_WINLEN_BASE = 9'h040;
  localparam logic [ADR_W-1:0] ADR_WINLEN_MASK = 9'h1E0;
  localparam logic [ADR_W-1:0] ADR_CNT_BASE    = 9'h060;
  localparam logic [ADR_W-1:0] ADR_CNT_MASK    = 9'h1F0;
  localparam logic [ADR_W-1:0] ADR_LOG_BASE    = 9'h100;
  localparam logic [ADR_W-1:0] ADR_LOG_MASK    = 9'h100;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int CTRL_FORCE_EN_BIT = 0;
  localparam int CTRL_FORCE_LSB    = 1;
  localparam int CTRL_SG_LSB       = 4;
  localparam int CTRL_CNT_CLR_BIT  = 8;
  localparam int LOGSTAT_CNT_LSB   = 8;

  localparam logic [7:0] EVMASK_RESET  = 8'hFF;
  localparam logic [7:0] IRQMASK_RESET = 8'h00;

  localparam int EV_INIT   = 0;
  localparam int EV_BLOCK  = 1;
  localparam int EV_ACTIVE = 2;
  localparam int EV_TRIP   = 3;

  localparam logic [7:0] LOG_EVENT_ACTIVE_ON = 8'h02;

  localparam logic [2:0] COND_NORMAL  = 3'h0;
  localparam logic [2:0] COND_INIT    = 3'h1;
  localparam logic [2:0] COND_ACTIVE  = 3'h2;
  localparam logic [2:0] COND_TRIP    = 3'h3;
  localparam logic [2:0] COND_BLOCKED = 3'h4;

  localparam logic [1:0] FORCE_NORMAL  = 2'h0;
  localparam logic [1:0] FORCE_BLOCKED = 2'h1;
  localparam logic [1:0] FORCE_ACTIVE  = 2'h2;
  localparam logic [1:0] FORCE_TRIP    = 2'h3;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WINDOW
  } sfg_state_t;

endpackage : sfg_pkg

/* File: verilog/sfg_log_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module sfg_log_mem
  import sfg_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              i_wr_en,
  input  wire logic [LOG_AW-1:0] i_wr_addr,
  input  wire logic [LOG_DW-1:0] i_wr_data,
  input  wire logic [LOG_AW-1:0] i_rd_addr,
  output var  logic [LOG_DW-1:0] o_rd_data
);

  logic [LOG_DW-1:0] mem [LOG_DEPTH];

  // ****************************************************************
  // Storage with registered read data
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end

endmodule : sfg_log_mem

`default_nettype wire

/* File: testbench/sfg_guard_props.sv */
`timescale 1ns/1ps
`default_nettype none

module sfg_guard_props
  import sfg_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
)(
  input wire logic             I_CLK,
  input wire logic             I_RST_N,
  input wire logic             I_WB_CYC,
  input wire logic             I_WB_STB,
  input wire logic             O_WB_ACK,
  input wire logic             I_ARM_TRIGGER_IN,
  input wire logic             I_INHIBIT_IN,
  input wire logic [FCN_W-1:0] I_STAGE_START_IN,
  input wire logic             O_WINDOW_ACTIVE_OUT,
  input wire logic             O_INSTANT_TRIP_OUT,
  input wire logic             O_INIT,
  input wire logic             O_BLOCKED,
  input wire logic             O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  chk_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property ($rose(I_WB_CYC && I_WB_STB) |=> O_WB_ACK)
    else $error("ack not one cycle after request");
  chk_trip_instant: assert property (
    (O_WINDOW_ACTIVE_OUT && |I_STAGE_START_IN) |-> O_INSTANT_TRIP_OUT)
    else $error("no instant trip in window");
  chk_trip_release: assert property (
    $fell(|I_STAGE_START_IN) |-> !O_INSTANT_TRIP_OUT)
    else $error("trip held after starts dropped");
  chk_arm_rise: assert property (
    ($rose(I_ARM_TRIGGER_IN) && !I_INHIBIT_IN && !O_WINDOW_ACTIVE_OUT)
    |=> O_WINDOW_ACTIVE_OUT)
    else $error("arm edge did not open window");
  chk_inhibit_block: assert property (
    (I_INHIBIT_IN && !O_WINDOW_ACTIVE_OUT) |-> O_BLOCKED)
    else $error("blocked not shown");
  chk_inhibit_noarm: assert property (
    (I_INHIBIT_IN && !O_WINDOW_ACTIVE_OUT) |=> !O_WINDOW_ACTIVE_OUT)
    else $error("window opened while inhibited");
  chk_irq_clear: assert property ($fell(O_IRQ) |-> O_WB_ACK)
    else $error("irq dropped without bus access");
  chk_init_level: assert property (O_INIT |-> I_ARM_TRIGGER_IN)
    else $error("init without arm input");

  cover property ($rose(O_INSTANT_TRIP_OUT));
  cover property ($fell(O_WINDOW_ACTIVE_OUT));
  cover property (O_BLOCKED && I_INHIBIT_IN);
endmodule : sfg_guard_props

bind sfg_guard sfg_guard_props #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_props (
  .I_CLK, .I_RST_N, .I_WB_CYC, .I_WB_STB, .O_WB_ACK, .I_ARM_TRIGGER_IN,
  .I_INHIBIT_IN, .I_STAGE_START_IN, .O_WINDOW_ACTIVE_OUT,
  .O_INSTANT_TRIP_OUT, .O_INIT, .O_BLOCKED, .O_IRQ
);

`default_nettype wire

/* File: testbench/sfg_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

// Breaker close and stage starts; slow mode delays starts by three cycles.
module sfg_far_end (
  input  wire logic       i_clk,
  input  wire logic       i_close,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_start,
  output var  logic       o_arm,
  output var  logic [7:0] o_start
);
  logic [7:0] d1_r;
  logic [7:0] d2_r;

  always_ff @(posedge i_clk) begin
    o_arm   <= i_close;
    d1_r    <= i_start;
    d2_r    <= d1_r;
    o_start <= i_slow ? d2_r : i_start;
  end
endmodule : sfg_far_end

`default_nettype wire

/* File: testbench/test_switch_on_fault_guard.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
  end \
end

module test_switch_on_fault_guard;
  import sfg_pkg::*;
  logic        clk, rst_n, we, cyc, stb, ack, close, slow, inhibit;
  logic        arm, active, trip, init, blocked, irq;
  logic [8:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  start_req, starts;
  int          fails, n_tests;
  int          win_len = 0;
  int          last_len = 0;
  logic [8:0]  row_adr [12] = '{9'h000, 9'h004, 9'h00C, 9'h010, 9'h040,
    9'h05C, 9'h024, 9'h068, 9'h068, 9'h06C, 9'h020, 9'h104};
  logic [31:0] row_exp [12] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0000,
    32'h0000_0000, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_0101,
    32'h0000_0201};

  sfg_guard #(.P_TICK_CYCLES(10)) dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_WB_ADR(adr), .I_WB_DAT(wdat),
    .I_WB_SEL(4'hF), .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_ARM_TRIGGER_IN(arm),
    .I_INHIBIT_IN(inhibit), .I_STAGE_START_IN(starts),
    .O_WINDOW_ACTIVE_OUT(active), .O_INSTANT_TRIP_OUT(trip),
    .O_INIT(init), .O_BLOCKED(blocked), .O_IRQ(irq));

  sfg_far_end far (.i_clk(clk), .i_close(close), .i_slow(slow),
    .i_start(start_req), .o_arm(arm), .o_start(starts));

  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      wb(1'b0, row_adr[i], 32'h0000_0000);
      `CHK("row", row_exp[i], q)
    end
  endtask : rows

  task pulse;
    @(posedge clk);
    close <= 1'b1;
    @(posedge clk);
    close <= 1'b0;
  endtask : pulse

  task wact(input logic v, input int lim);
    for (int i = 0; i < lim && active !== v; i++) @(negedge clk);
  endtask : wact

  always @(posedge clk) begin
    if (active) win_len <= win_len + 1;
    else if (win_len != 0) begin
      last_len <= win_len;
      win_len  <= 0;
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict;
  end

  initial begin
    {rst_n, we, cyc, stb, close, slow, inhibit} = '0;
    {adr, wdat, start_req, fails, n_tests} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rows(0, 7);
    $display("test reset values done");
    wb(1'b1, 9'h000, 32'h0000_0010);
    wb(1'b1, 9'h044, 32'h0000_0005);
    pulse;
    wact(1'b1, 10);
    `CHK("active", 1'b1, active)
    wb(1'b0, 9'h010, 32'h0000_0000);
    `CHK("cond", 32'h0000_0002, q)
    slow      <= 1'b1;
    start_req <= 8'h20;
    wait (starts != 8'h00);
    @(negedge clk);
    `CHK("trip", 1'b1, trip)
    @(posedge clk);
    start_req <= 8'h00;
    wait (starts == 8'h00);
    @(negedge clk);
    `CHK("trip off", 1'b0, trip)
    wact(1'b0, 80);
    @(negedge clk);
    `CHK("len", 1'b1, (last_len >= 39 && last_len <= 51))
    rows(8, 11);
    $display("test window and log done");
    `CHK("irq masked", 1'b0, irq)
    wb(1'b1, 9'h00C, 32'h0000_0008);
    `CHK("irq", 1'b1, irq)
    wb(1'b0, 9'h008, 32'h0000_0000);
    `CHK("status", 32'h0000_00DD, q)
    `CHK("irq clr", 1'b0, irq)
    $display("test events done");
    inhibit <= 1'b1;
    pulse;
    @(negedge clk);
    `CHK("init", 1'b1, init)
    repeat (2) @(negedge clk);
    `CHK("inh act", 1'b0, active)
    `CHK("blocked", 1'b1, blocked)
    wb(1'b0, 9'h010, 32'h0000_0000);
    `CHK("cond blk", 32'h0000_0004, q)
    inhibit <= 1'b0;
    $display("test inhibit done");
    wb(1'b1, 9'h000, 32'h0000_0000);
    pulse;
    wact(1'b1, 10);
    wb(1'b1, 9'h000, 32'h0000_0010);
    wact(1'b0, 80);
    `CHK("sg change", 1'b0, active)
    $display("test group change done");
    wb(1'b1, 9'h000, 32'h0000_0007);
    `CHK("f trip", 1'b1, trip)
    wb(1'b1, 9'h000, 32'h0000_0005);
    `CHK("f act", 1'b1, active)
    wb(1'b1, 9'h000, 32'h0000_0003);
    `CHK("f blk", 1'b1, blocked)
    wb(1'b1, 9'h000, 32'h0000_0000);
    `CHK("f norm", 1'b0, active)
    wb(1'b1, 9'h000, 32'h0000_0100);
    wb(1'b0, 9'h060, 32'h0000_0000);
    `CHK("cnt clr", 32'h0000_0000, q)
    $display("test forcing done");
    pulse;
    wact(1'b1, 10);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("rst act", 1'b0, active)
    rows(0, 7);
    $display("test mid reset done");
    give_verdict;
  end
endmodule : test_switch_on_fault_guard

`undef CHK
`default_nettype wire
